// ===== logic/crsu_top.sv
`timescale 1ns/1ps
`include "crsu_cfg.svh"
module crsu_top (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic               cmdValid,
	input  wire crsu_pkg::crsu_cmd_t cmd,
	input  wire logic [15:0]        cmdData,
	input  wire logic               intReq,
	input  wire logic [15:0]        intVector,
	input  wire logic [7:0]         flagsIn,
	input  wire logic [7:0]         memRdata,
	output logic                    cmdReady,
	output logic                    intAck,
	output logic [15:0]             memAddr,
	output logic [7:0]              memWdata,
	output logic                    memWe,
	output logic                    memRe,
	output logic [7:0]              accHi,
	output logic [7:0]              accLo,
	output logic [15:0]             ix1,
	output logic [15:0]             ix2,
	output logic [15:0]             sp,
	output logic [15:0]             pc,
	output logic [15:0]             ea,
	output logic                    eaValid,
	output logic [7:0]              flagsOut,
	output logic                    flagsLoad,
	output crsu_pkg::crsu_flags_t   aluFlags,
	output logic                    aluFlagsValid
);
	import crsu_pkg::*;

	////////////////////////////////////////////////////////////////
	// helpers

	// indexed address: 16-bit base plus unsigned 8-bit offset
	function automatic logic [15:0] addOff(input logic [15:0] base, input logic [7:0] off);
		addOff = base + {`CRSU_ZERO8, off};
	endfunction

	////////////////////////////////////////////////////////////////
	// state

	crsu_state_t state_r, state_nxt;
	crsu_kind_t  kind_r, kind_nxt;
	logic [3:0]  step_r, step_nxt;
	logic [3:0]  stop_r, stop_nxt;
	logic [15:0] tgt_r, tgt_nxt;
	logic        vlo_r, vlo_nxt;
	logic [7:0]  accHi_r, accHi_nxt;
	logic [7:0]  accLo_r, accLo_nxt;
	logic [15:0] ix1_r, ix1_nxt;
	logic [15:0] ix2_r, ix2_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] ea_r, ea_nxt;
	logic        eaValid_r, eaValid_nxt;
	logic [7:0]  flagsOut_r, flagsOut_nxt;
	logic        flagsLoad_r, flagsLoad_nxt;
	crsu_flags_t aluFlags_r, aluFlags_nxt;
	logic        aluFlagsValid_r, aluFlagsValid_nxt;
	logic [15:0] memAddr_r, memAddr_nxt;
	logic [7:0]  memWdata_r, memWdata_nxt;
	logic        memWe_r, memWe_nxt;
	logic        memRe_r, memRe_nxt;
	logic        intAck_r, intAck_nxt;
	logic        cmdTake;
	logic        intTake;
	logic [7:0]  pushByte;

	crsu_alu_if aluBus ();

	crsu_alu u_alu (
		.bus (aluBus.alu)
	);

	// commands win over a pending interrupt so the running instruction completes
	assign cmdTake = ce && cmdValid && (state_r == ST_IDLE);
	assign intTake = ce && intReq && !cmdValid && (state_r == ST_IDLE); // RL15

	// alu operands: first accumulator left, second right, never swapped
	always_comb
	begin
		aluBus.a   = accHi_r; // RL7
		aluBus.b   = accLo_r;
		aluBus.cIn = flagsIn[`CRSU_CCR_C];
		aluBus.hIn = flagsIn[`CRSU_CCR_H];
		case (cmd)
			CMD_ADD_ACCS:           aluBus.op = ALU_ADD;
			CMD_DECIMAL_ADJUST_ACC: aluBus.op = ALU_DEC_ADJ;
			default:                aluBus.op = ALU_SUB;
		endcase
	end

	// byte pushed at each stacking step, low byte before high
	always_comb
	begin
		case (step_r)
			`CRSU_ST_PCL: pushByte = pc_r[7:0]; // RL16
			`CRSU_ST_PCH: pushByte = pc_r[15:8];
			`CRSU_ST_IYL: pushByte = ix2_r[7:0];
			`CRSU_ST_IYH: pushByte = ix2_r[15:8];
			`CRSU_ST_IXL: pushByte = ix1_r[7:0];
			`CRSU_ST_IXH: pushByte = ix1_r[15:8];
			`CRSU_ST_ACL: pushByte = accLo_r;
			`CRSU_ST_ACH: pushByte = accHi_r;
			default:      pushByte = flagsIn;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb
	begin
		state_nxt         = state_r;
		kind_nxt          = kind_r;
		step_nxt          = step_r;
		stop_nxt          = stop_r;
		tgt_nxt           = tgt_r;
		vlo_nxt           = vlo_r;
		accHi_nxt         = accHi_r;
		accLo_nxt         = accLo_r;
		ix1_nxt           = ix1_r;
		ix2_nxt           = ix2_r;
		sp_nxt            = sp_r;
		pc_nxt            = pc_r;
		ea_nxt            = ea_r;
		eaValid_nxt       = 1'b0;
		flagsOut_nxt      = flagsOut_r;
		flagsLoad_nxt     = 1'b0;
		aluFlags_nxt      = aluFlags_r;
		aluFlagsValid_nxt = 1'b0;
		memAddr_nxt       = memAddr_r;
		memWdata_nxt      = memWdata_r;
		memWe_nxt         = 1'b0;
		memRe_nxt         = 1'b0;
		intAck_nxt        = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				kind_nxt = K_PLAIN;
				if (cmdTake)
				begin
					case (cmd)
						CMD_LOAD_A:   accHi_nxt = cmdData[7:0]; // RL1
						CMD_LOAD_B:   accLo_nxt = cmdData[7:0];
						CMD_LOAD_D:
						begin
							accHi_nxt = cmdData[15:8]; // RL2 RL3
							accLo_nxt = cmdData[7:0];
						end
						CMD_LOAD_IX1: ix1_nxt = cmdData;
						CMD_LOAD_IX2: ix2_nxt = cmdData;
						CMD_LOAD_SP:  sp_nxt = cmdData; // RL12
						CMD_JUMP:     pc_nxt = cmdData;
						CMD_ADD_LOW_ACC_IX1: ix1_nxt = addOff(ix1_r, accLo_r); // RL4
						CMD_ADD_LOW_ACC_IX2: ix2_nxt = addOff(ix2_r, accLo_r); // RL4
						CMD_COPY_ACC_TO_FLAGS:
						begin
							flagsOut_nxt  = accHi_r; // RL5
							flagsLoad_nxt = 1'b1;
						end
						CMD_COPY_FLAGS_TO_ACC: accHi_nxt = flagsIn; // RL5
						CMD_DECIMAL_ADJUST_ACC, CMD_ADD_ACCS, CMD_SUBTRACT_ACCS, CMD_COMPARE_ACCS:
						begin
							if (cmd != CMD_COMPARE_ACCS)
							begin
								accHi_nxt = aluBus.res; // RL6 RL7
							end
							aluFlags_nxt      = aluBus.flg;
							aluFlagsValid_nxt = 1'b1;
						end
						CMD_EA_IX1:
						begin
							ea_nxt      = addOff(ix1_r, cmdData[7:0]); // RL8
							eaValid_nxt = 1'b1;
						end
						CMD_EA_IX2:
						begin
							tgt_nxt   = addOff(ix2_r, cmdData[7:0]); // RL9
							state_nxt = ST_EA2;
						end
						CMD_INC_IX1: ix1_nxt = ix1_r + `CRSU_ONE16; // RL8
						CMD_DEC_IX1: ix1_nxt = ix1_r - `CRSU_ONE16;
						CMD_PUSH_A, CMD_PUSH_B, CMD_PUSH_IX1, CMD_PUSH_IX2:
						begin
							state_nxt = ST_PUSH; // RL18
							case (cmd)
								CMD_PUSH_A:   step_nxt = `CRSU_ST_ACH;
								CMD_PUSH_B:   step_nxt = `CRSU_ST_ACL;
								CMD_PUSH_IX1: step_nxt = `CRSU_ST_IXL;
								default:      step_nxt = `CRSU_ST_IYL;
							endcase
							case (cmd)
								CMD_PUSH_A:   stop_nxt = `CRSU_ST_ACH;
								CMD_PUSH_B:   stop_nxt = `CRSU_ST_ACL;
								CMD_PUSH_IX1: stop_nxt = `CRSU_ST_IXH;
								default:      stop_nxt = `CRSU_ST_IYH;
							endcase
						end
						CMD_PULL_A, CMD_PULL_B, CMD_PULL_IX1, CMD_PULL_IX2:
						begin
							state_nxt = ST_PULL_RD; // RL18
							case (cmd)
								CMD_PULL_A:   step_nxt = `CRSU_ST_ACH;
								CMD_PULL_B:   step_nxt = `CRSU_ST_ACL;
								CMD_PULL_IX1: step_nxt = `CRSU_ST_IXH;
								default:      step_nxt = `CRSU_ST_IYH;
							endcase
							case (cmd)
								CMD_PULL_A:   stop_nxt = `CRSU_ST_ACH;
								CMD_PULL_B:   stop_nxt = `CRSU_ST_ACL;
								CMD_PULL_IX1: stop_nxt = `CRSU_ST_IXL;
								default:      stop_nxt = `CRSU_ST_IYL;
							endcase
						end
						CMD_JUMP_SUBROUTINE:
						begin
							kind_nxt  = K_CALL; // RL13
							tgt_nxt   = cmdData;
							step_nxt  = `CRSU_ST_PCL;
							stop_nxt  = `CRSU_ST_PCH;
							state_nxt = ST_PUSH;
						end
						CMD_SUBROUTINE_RETURN:
						begin
							step_nxt  = `CRSU_ST_PCH; // RL14
							stop_nxt  = `CRSU_ST_PCL;
							state_nxt = ST_PULL_RD;
						end
						CMD_INTERRUPT_RETURN:
						begin
							step_nxt  = `CRSU_ST_CCR; // RL17
							stop_nxt  = `CRSU_ST_PCL;
							state_nxt = ST_PULL_RD;
						end
						default:
						begin
							state_nxt = ST_IDLE;
						end
					endcase
				end
				else if (intTake)
				begin
					kind_nxt  = K_INT; // RL15
					tgt_nxt   = intVector;
					step_nxt  = `CRSU_ST_PCL;
					stop_nxt  = `CRSU_ST_CCR;
					state_nxt = ST_PUSH;
				end
			end
			ST_PUSH:
			begin
				memWe_nxt    = 1'b1; // RL19
				memAddr_nxt  = sp_r; // RL11
				memWdata_nxt = pushByte;
				sp_nxt       = sp_r - `CRSU_ONE16; // RL10
				step_nxt     = step_r + `CRSU_STEP1;
				if (step_r == stop_r)
				begin
					if (kind_r == K_INT)
					begin
						vlo_nxt   = 1'b0;
						state_nxt = ST_VEC_RD;
					end
					else
					begin
						if (kind_r == K_CALL)
						begin
							pc_nxt = tgt_r; // RL13
						end
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_PULL_RD:
			begin
				memRe_nxt   = 1'b1;
				memAddr_nxt = sp_r + `CRSU_ONE16;
				sp_nxt      = sp_r + `CRSU_ONE16; // RL10
				state_nxt   = ST_PULL_WAIT;
			end
			ST_PULL_WAIT:
			begin
				case (step_r)
					`CRSU_ST_PCL: pc_nxt[7:0] = memRdata; // RL14 RL17
					`CRSU_ST_PCH: pc_nxt[15:8] = memRdata;
					`CRSU_ST_IYL: ix2_nxt[7:0] = memRdata;
					`CRSU_ST_IYH: ix2_nxt[15:8] = memRdata;
					`CRSU_ST_IXL: ix1_nxt[7:0] = memRdata;
					`CRSU_ST_IXH: ix1_nxt[15:8] = memRdata;
					`CRSU_ST_ACL: accLo_nxt = memRdata;
					`CRSU_ST_ACH: accHi_nxt = memRdata;
					default:
					begin
						flagsOut_nxt  = memRdata;
						flagsLoad_nxt = 1'b1;
					end
				endcase
				step_nxt  = step_r - `CRSU_STEP1;
				state_nxt = (step_r == stop_r) ? ST_IDLE : ST_PULL_RD;
			end
			ST_VEC_RD:
			begin
				memRe_nxt   = 1'b1;
				memAddr_nxt = vlo_r ? (tgt_r + `CRSU_ONE16) : tgt_r;
				state_nxt   = ST_VEC_WAIT;
			end
			ST_VEC_WAIT:
			begin
				vlo_nxt = 1'b1;
				if (vlo_r)
				begin
					pc_nxt[7:0] = memRdata; // RL21
					intAck_nxt  = (kind_r == K_INT);
					state_nxt   = ST_IDLE;
				end
				else
				begin
					pc_nxt[15:8] = memRdata;
					state_nxt    = ST_VEC_RD;
				end
			end
			default:
			begin
				ea_nxt      = tgt_r; // RL9
				eaValid_nxt = 1'b1;
				state_nxt   = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registers; no path maps them into memory space

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r         <= ST_VEC_RD; // RL21
			kind_r          <= K_PLAIN;
			step_r          <= `CRSU_ST_PCL;
			stop_r          <= `CRSU_ST_PCL;
			tgt_r           <= `CRSU_RESET_VEC;
			vlo_r           <= 1'b0;
			accHi_r         <= `CRSU_ZERO8;
			accLo_r         <= `CRSU_ZERO8;
			ix1_r           <= `CRSU_ZERO16;
			ix2_r           <= `CRSU_ZERO16;
			sp_r            <= `CRSU_SP_RST;
			pc_r            <= `CRSU_ZERO16;
			ea_r            <= `CRSU_ZERO16;
			eaValid_r       <= 1'b0;
			flagsOut_r      <= `CRSU_ZERO8;
			flagsLoad_r     <= 1'b0;
			aluFlags_r      <= '0;
			aluFlagsValid_r <= 1'b0;
			memAddr_r       <= `CRSU_ZERO16;
			memWdata_r      <= `CRSU_ZERO8;
			memWe_r         <= 1'b0;
			memRe_r         <= 1'b0;
			intAck_r        <= 1'b0;
			cmdReady        <= 1'b0;
		end
		else if (ce)
		begin
			state_r         <= state_nxt;
			kind_r          <= kind_nxt;
			step_r          <= step_nxt;
			stop_r          <= stop_nxt;
			tgt_r           <= tgt_nxt;
			vlo_r           <= vlo_nxt;
			accHi_r         <= accHi_nxt;
			accLo_r         <= accLo_nxt;
			ix1_r           <= ix1_nxt;
			ix2_r           <= ix2_nxt;
			sp_r            <= sp_nxt;
			pc_r            <= pc_nxt;
			ea_r            <= ea_nxt;
			eaValid_r       <= eaValid_nxt;
			flagsOut_r      <= flagsOut_nxt;
			flagsLoad_r     <= flagsLoad_nxt;
			aluFlags_r      <= aluFlags_nxt;
			aluFlagsValid_r <= aluFlagsValid_nxt;
			memAddr_r       <= memAddr_nxt;
			memWdata_r      <= memWdata_nxt;
			memWe_r         <= memWe_nxt;
			memRe_r         <= memRe_nxt;
			intAck_r        <= intAck_nxt;
			cmdReady        <= (state_nxt == ST_IDLE);
		end
	end

	// outputs straight from flops
	assign accHi = accHi_r;
	assign accLo = accLo_r;
	assign ix1 = ix1_r;
	assign ix2 = ix2_r;
	assign sp = sp_r;
	assign pc = pc_r;
	assign ea = ea_r;
	assign eaValid = eaValid_r;
	assign flagsOut = flagsOut_r;
	assign flagsLoad = flagsLoad_r;
	assign aluFlags = aluFlags_r;
	assign aluFlagsValid = aluFlagsValid_r;
	assign memAddr = memAddr_r; // RL20
	assign memWdata = memWdata_r;
	assign memWe = memWe_r;
	assign memRe = memRe_r;
	assign intAck = intAck_r;

	////////////////////////////////////////////////////////////////
	// checks

	property p_pushSp;
		@(posedge clk) disable iff (!rst_n) (ce && state_r == ST_PUSH) |=>
			(memWe_r && memAddr_r == $past(sp_r) && sp_r == $past(sp_r) - `CRSU_ONE16);
	endproperty
	a_pushSp: assert property (p_pushSp) else $error("push not at pointer or no decrement"); // RL11
	property p_pullSp;
		@(posedge clk) disable iff (!rst_n) (ce && state_r == ST_PULL_RD) |=>
			(memRe_r && sp_r == $past(sp_r) + `CRSU_ONE16 && memAddr_r == sp_r);
	endproperty
	a_pullSp: assert property (p_pullSp) else $error("pull did not increment pointer"); // RL10
	property p_callLowFirst;
		@(posedge clk) disable iff (!rst_n) (cmdTake && cmd == CMD_JUMP_SUBROUTINE) ##1 ce |=>
			(memWe_r && memWdata_r == $past(pc_r[7:0], 2));
	endproperty
	a_callLowFirst: assert property (p_callLowFirst) else $error("call did not push low byte first"); // RL13
	property p_intStack;
		@(posedge clk) disable iff (!rst_n || !ce) intTake |=> 1'b1 ##1 memWe_r [*8] ##1 memWe_r ##1 (!memWe_r && memRe_r);
	endproperty
	a_intStack: assert property (p_intStack) else $error("interrupt did not stack nine bytes"); // RL16
	property p_addLow;
		@(posedge clk) disable iff (!rst_n) (cmdTake && cmd == CMD_ADD_LOW_ACC_IX1) |=>
			(ix1_r == $past(ix1_r) + {`CRSU_ZERO8, $past(accLo_r)} && accHi_r == $past(accHi_r));
	endproperty
	a_addLow: assert property (p_addLow) else $error("second accumulator add to index wrong"); // RL4
	property p_eaOne;
		@(posedge clk) disable iff (!rst_n) (cmdTake && cmd == CMD_EA_IX1) |=>
			(eaValid_r && ea_r == $past(ix1_r) + {`CRSU_ZERO8, $past(cmdData[7:0])});
	endproperty
	a_eaOne: assert property (p_eaOne) else $error("index one address wrong"); // RL8
	property p_eaTwo;
		@(posedge clk) disable iff (!rst_n || !ce) (cmdTake && cmd == CMD_EA_IX2) |=>
			!eaValid_r ##1 (eaValid_r && ea_r == $past(ix2_r, 2) + {`CRSU_ZERO8, $past(cmdData[7:0], 2)});
	endproperty
	a_eaTwo: assert property (p_eaTwo) else $error("index two address not one cycle later"); // RL9
	property p_loadD;
		@(posedge clk) disable iff (!rst_n) (cmdTake && cmd == CMD_LOAD_D) |=>
			(accHi_r == $past(cmdData[15:8]) && accLo_r == $past(cmdData[7:0]));
	endproperty
	a_loadD: assert property (p_loadD) else $error("double accumulator byte order wrong"); // RL3
	property p_toFlags;
		@(posedge clk) disable iff (!rst_n) (cmdTake && cmd == CMD_COPY_ACC_TO_FLAGS) |=>
			(flagsLoad_r && flagsOut_r == $past(accHi_r));
	endproperty
	a_toFlags: assert property (p_toFlags) else $error("flag transfer not from first accumulator"); // RL5
endmodule

// ===== logic/crsu_cfg.svh
// Function
// (RL1) two 8-bit accumulators hold operands, results
// (RL2) both accumulators pair into one 16-bit accumulator
// (RL3) first accumulator is upper byte, second lower
// (RL4) second accumulator adds to either index register
// (RL5) flag transfers only with the first accumulator
// (RL6) decimal adjust only on first accumulator
// (RL7) accumulator add/subtract/compare in one order only
// (RL8) index one plus offset forms address; counter
// (RL9) index two same, one extra cycle; the code has no increment or decrement for index two
// (RL10) push decrements pointer, pull increments it
// (RL11) pointer addresses next free location
// (RL12) stack pointer loadable anywhere by software
// (RL13) subroutine call pushes return address, low first
// (RL14) subroutine return pulls address into program counter
// (RL15) interrupt: finish instruction, stack all, vector
// (RL16) stack order: PC, index two, one, accs, flags
// (RL17) interrupt return pulls in reverse stacking order
// (RL18) explicit push and pull per accumulator, index
// (RL19) one uniform 64-Kbyte memory map, no I/O path
// (RL20) processor registers absent from memory map
// (RL21) program counter loaded from reset vector
`ifndef CRSU_CFG_SVH
`define CRSU_CFG_SVH
`define CRSU_RESET_VEC    16'hFFFE
`define CRSU_SP_RST       16'h00FF
`define CRSU_ONE16        16'h0001
`define CRSU_ZERO8        8'h00
`define CRSU_ZERO16       16'h0000
`define CRSU_CCR_C        0
`define CRSU_CCR_H        5
`define CRSU_BCD_NIB_MAX  4'h9
`define CRSU_BCD_BYTE_MAX 8'h99
`define CRSU_BCD_LO_FIX   8'h06
`define CRSU_BCD_HI_FIX   8'h60
`define CRSU_STEP1        4'h1
`define CRSU_ST_PCL       4'h0
`define CRSU_ST_PCH       4'h1
`define CRSU_ST_IYL       4'h2
`define CRSU_ST_IYH       4'h3
`define CRSU_ST_IXL       4'h4
`define CRSU_ST_IXH       4'h5
`define CRSU_ST_ACL       4'h6
`define CRSU_ST_ACH       4'h7
`define CRSU_ST_CCR       4'h8
`endif

// ===== logic/crsu_pkg.sv
package crsu_pkg;
	typedef enum logic [4:0] {
		CMD_NOP, CMD_LOAD_A, CMD_LOAD_B, CMD_LOAD_D, CMD_LOAD_IX1, CMD_LOAD_IX2, CMD_LOAD_SP, CMD_JUMP,
		CMD_ADD_LOW_ACC_IX1, CMD_ADD_LOW_ACC_IX2, CMD_COPY_ACC_TO_FLAGS, CMD_COPY_FLAGS_TO_ACC,
		CMD_DECIMAL_ADJUST_ACC, CMD_ADD_ACCS, CMD_SUBTRACT_ACCS, CMD_COMPARE_ACCS,
		CMD_EA_IX1, CMD_EA_IX2, CMD_INC_IX1, CMD_DEC_IX1,
		CMD_PUSH_A, CMD_PUSH_B, CMD_PUSH_IX1, CMD_PUSH_IX2, CMD_PULL_A, CMD_PULL_B, CMD_PULL_IX1, CMD_PULL_IX2,
		CMD_JUMP_SUBROUTINE, CMD_SUBROUTINE_RETURN, CMD_INTERRUPT_RETURN
	} crsu_cmd_t;
	typedef enum {ST_IDLE, ST_PUSH, ST_PULL_RD, ST_PULL_WAIT, ST_VEC_RD, ST_VEC_WAIT, ST_EA2} crsu_state_t;
	typedef enum {K_PLAIN, K_CALL, K_INT} crsu_kind_t;
	typedef enum {ALU_ADD, ALU_SUB, ALU_DEC_ADJ} crsu_aluop_t;
	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} crsu_flags_t;
endpackage

// ===== logic/crsu_alu_if.sv
`timescale 1ns/1ps
interface crsu_alu_if;
	import crsu_pkg::*;
	logic [7:0]  a;
	logic [7:0]  b;
	crsu_aluop_t op;
	logic        cIn;
	logic        hIn;
	logic [7:0]  res;
	crsu_flags_t flg;
	modport alu  (input a, b, op, cIn, hIn, output res, flg);
	modport user (output a, b, op, cIn, hIn, input res, flg);
endinterface

// ===== logic/crsu_alu.sv
`timescale 1ns/1ps
`include "crsu_cfg.svh"
module crsu_alu (
	crsu_alu_if.alu bus
);
	import crsu_pkg::*;
	logic [8:0] sum9;
	logic [8:0] dif9;
	logic [4:0] half5;
	logic       lowFix;
	logic       highFix;
	logic [7:0] corr;

	// byte arithmetic, first accumulator always the left operand
	always_comb
	begin
		sum9    = {1'b0, bus.a} + {1'b0, bus.b};
		dif9    = {1'b0, bus.a} - {1'b0, bus.b};
		half5   = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
		lowFix  = bus.hIn || (bus.a[3:0] > `CRSU_BCD_NIB_MAX);
		highFix = bus.cIn || (bus.a > `CRSU_BCD_BYTE_MAX);
		corr    = (highFix ? `CRSU_BCD_HI_FIX : `CRSU_ZERO8) | (lowFix ? `CRSU_BCD_LO_FIX : `CRSU_ZERO8);
		bus.flg = '0;
		case (bus.op)
			ALU_ADD:
			begin
				bus.res   = sum9[7:0];
				bus.flg.c = sum9[8];
				bus.flg.h = half5[4];
				bus.flg.v = (bus.a[7] == bus.b[7]) && (sum9[7] != bus.a[7]);
			end
			ALU_SUB:
			begin
				bus.res   = dif9[7:0];
				bus.flg.c = dif9[8];
				bus.flg.v = (bus.a[7] != bus.b[7]) && (dif9[7] != bus.a[7]);
			end
			default:
			begin
				bus.res   = bus.a + corr; // RL6
				bus.flg.c = highFix;
				bus.flg.h = bus.hIn;
			end
		endcase
		bus.flg.n = bus.res[7];
		bus.flg.z = (bus.res == `CRSU_ZERO8);
	end
endmodule

// ===== verif/crsu_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// flat 64-kbyte memory map, zero-wait writes, async reads
module crsu_mem_model #(
	parameter logic [15:0] RST_PC  = 16'h1234,
	parameter logic [15:0] INT_VEC = 16'hFFF0,
	parameter logic [15:0] INT_PC  = 16'hC000
) (
	input  wire logic        clk,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	input  wire logic        memWe,
	input  wire logic        memRe,
	output logic [7:0]       memRdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastRd_r;
	// preset vectors, all other bytes cleared
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
		{mem[16'hFFFE], mem[16'hFFFF]} = RST_PC;
		{mem[INT_VEC], mem[INT_VEC + 16'h0001]} = INT_PC;
		lastRd_r = 8'h00;
	end
	// every address decoded the same way, no wait states
	always @(posedge clk)
	begin
		if (memWe)
			mem[memAddr] <= memWdata;
		if (memRe)
			lastRd_r <= mem[memAddr];
	end
	// released bus shows a changed value, not the last byte
	assign memRdata = memRe ? mem[memAddr] : ~lastRd_r;
endmodule

// ===== verif/crsu_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module crsu_top_test;
	import crsu_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        cmdValid = 1'b0;
	crsu_cmd_t   cmd = CMD_NOP;
	logic [15:0] cmdData = 16'h0000;
	logic        intReq = 1'b0;
	logic [15:0] intVector = 16'hFFF0;
	logic [7:0]  flagsIn = 8'h00;
	logic [7:0]  memRdata;
	logic        cmdReady, intAck, memWe, memRe, eaValid, flagsLoad, aluFlagsValid;
	logic [15:0] memAddr, ix1, ix2, sp, pc, ea;
	logic [7:0]  memWdata, accHi, accLo, flagsOut;
	crsu_flags_t aluFlags;
	int          num_errors = 0;
	int          checked = 0;
	logic [7:0]  stk [0:8];
	int          n1, n2;
	// half-period toggle for 200 MHz
	always #2.5 clk = ~clk;
	crsu_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid), .cmd(cmd), .cmdData(cmdData),
		.intReq(intReq), .intVector(intVector), .flagsIn(flagsIn), .memRdata(memRdata), .cmdReady(cmdReady),
		.intAck(intAck), .memAddr(memAddr), .memWdata(memWdata), .memWe(memWe), .memRe(memRe), .accHi(accHi),
		.accLo(accLo), .ix1(ix1), .ix2(ix2), .sp(sp), .pc(pc), .ea(ea), .eaValid(eaValid), .flagsOut(flagsOut),
		.flagsLoad(flagsLoad), .aluFlags(aluFlags), .aluFlagsValid(aluFlagsValid));
	crsu_mem_model u_mem (.clk(clk), .memAddr(memAddr), .memWdata(memWdata), .memWe(memWe), .memRe(memRe),
		.memRdata(memRdata));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait at falling edges for the idle flag
	task automatic wait_ready();
		for (int i = 0; i < 64 && cmdReady !== 1'b1; i++)
			@(negedge clk);
		chk({15'h0000, cmdReady}, 16'h0001);
	endtask
	// one request held across its taking edge, released after
	task automatic issue(input crsu_cmd_t c, input logic [15:0] d);
		@(negedge clk);
		wait_ready();
		cmdValid = 1'b1;
		cmd = c;
		cmdData = d;
		@(negedge clk);
		cmdValid = 1'b0;
	endtask
	task automatic run(input crsu_cmd_t c, input logic [15:0] d);
		issue(c, d);
		@(negedge clk);
		wait_ready();
		@(negedge clk); // lets the model store the last pushed byte
	endtask
	// falling edges from release until the address pulse
	task automatic ea_lat(input crsu_cmd_t c, input logic [7:0] off, output int n);
		issue(c, {8'h00, off});
		n = 0;
		while (eaValid !== 1'b1 && n < 6)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		wait_ready();
		chk(pc, 16'h1234);
		chk(sp, 16'h00FF);
	endtask
	// a held request is not taken while the enable is low
	task automatic t_freeze();
		@(negedge clk);
		ce = 1'b0;
		cmdValid = 1'b1;
		cmd = CMD_LOAD_A;
		cmdData = 16'h00EE;
		repeat (3) @(negedge clk);
		chk({accHi, 7'h00, cmdReady}, 16'h0001);
		ce = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
		chk({accHi, 8'h00}, 16'hEE00);
	endtask
	task automatic t_accs();
		run(CMD_LOAD_D, 16'hA55A);
		chk({accHi, 8'h00}, 16'hA500);
		chk({8'h00, accLo}, 16'h005A);
		run(CMD_LOAD_A, 16'h0019);
		run(CMD_LOAD_B, 16'h0028);
		chk({accHi, accLo}, 16'h1928);
		run(CMD_ADD_ACCS, 16'h0000);
		chk({accHi, accLo}, 16'h4128);
		chk({11'h000, aluFlags}, 16'h0010);
		flagsIn = 8'h20;
		run(CMD_DECIMAL_ADJUST_ACC, 16'h0000);
		chk({accHi, accLo}, 16'h4728);
		run(CMD_SUBTRACT_ACCS, 16'h0000);
		chk({accHi, accLo}, 16'h1F28);
		run(CMD_LOAD_B, 16'h001F);
		run(CMD_COMPARE_ACCS, 16'h0000);
		chk({accHi, 7'h00, aluFlags.z}, 16'h1F01);
		flagsIn = 8'hC5;
		run(CMD_COPY_FLAGS_TO_ACC, 16'h0000);
		chk({accHi, accLo}, 16'hC51F);
		run(CMD_COPY_ACC_TO_FLAGS, 16'h0000);
		chk({8'h00, flagsOut}, 16'h00C5);
	endtask
	task automatic t_index();
		run(CMD_LOAD_IX1, 16'h1000);
		run(CMD_LOAD_IX2, 16'h2000);
		run(CMD_ADD_LOW_ACC_IX1, 16'h0000);
		run(CMD_ADD_LOW_ACC_IX2, 16'h0000);
		chk(ix1, 16'h101F);
		chk(ix2, 16'h201F);
		ea_lat(CMD_EA_IX1, 8'hF0, n1);
		chk(ea, 16'h110F);
		ea_lat(CMD_EA_IX2, 8'hF0, n2);
		chk(ea, 16'h210F);
		chk(n2[15:0], n1[15:0] + 16'h0001);
		run(CMD_INC_IX1, 16'h0000);
		chk(ix1, 16'h1020);
	endtask
	task automatic t_stack();
		run(CMD_LOAD_SP, 16'h0800);
		run(CMD_PUSH_A, 16'h0000);
		chk({u_mem.mem[16'h0800], 8'h00}, 16'hC500);
		chk(sp, 16'h07FF);
		run(CMD_PUSH_IX1, 16'h0000);
		chk({u_mem.mem[16'h07FE], u_mem.mem[16'h07FF]}, 16'h1020);
		chk(sp, 16'h07FD);
		run(CMD_PULL_B, 16'h0000);
		chk({sp[7:0], accLo}, 16'hFE10);
		run(CMD_PULL_IX2, 16'h0000);
		chk(ix2, 16'h20C5);
		chk(sp, 16'h0800);
	endtask
	task automatic t_call();
		run(CMD_JUMP, 16'h4321);
		run(CMD_JUMP_SUBROUTINE, 16'h5000);
		chk({u_mem.mem[16'h07FF], u_mem.mem[16'h0800]}, 16'h4321);
		chk({pc[15:8], sp[7:0]}, 16'h50FE);
		run(CMD_SUBROUTINE_RETURN, 16'h0000);
		chk(pc, 16'h4321);
		chk(sp, 16'h0800);
	endtask
	task automatic t_int();
		flagsIn = 8'h5A;
		stk = '{8'h21, 8'h43, 8'hC5, 8'h20, 8'h20, 8'h10, 8'h10, 8'hC5, 8'h5A};
		@(negedge clk);
		intReq = 1'b1;
		for (int i = 0; i < 64 && intAck !== 1'b1; i++)
			@(negedge clk);
		intReq = 1'b0;
		chk({15'h0000, intAck}, 16'h0001);
		chk(pc, 16'hC000);
		chk(sp, 16'h07F7);
		for (int i = 0; i < 9; i++)
			chk({8'h00, u_mem.mem[16'h0800 - i]}, {8'h00, stk[i]});
		run(CMD_LOAD_D, 16'h0000);
		run(CMD_LOAD_IX1, 16'h0000);
		run(CMD_LOAD_IX2, 16'h0000);
		run(CMD_INTERRUPT_RETURN, 16'h0000);
		chk(pc, 16'h4321);
		chk({accHi, accLo}, 16'hC510);
		chk(ix1, 16'h1020);
		chk(ix2, 16'h20C5);
		chk({sp[7:0], flagsOut}, 16'h005A);
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog on a span far beyond the sequence length
	initial
	begin
		#20000;
		num_errors++;
		wrap_up();
	end
	// reset held 8 cycles, then the scenarios in order
	initial
	begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_freeze();
		t_accs();
		t_index();
		t_stack();
		t_call();
		t_int();
		wrap_up();
	end
endmodule
